// ### design/adcp_pkg.sv
package adcp_pkg;
    // data path widths
    localparam int DATA_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int REG_W       = 14;
    localparam int CODE_W      = 12;
    localparam int CAL_REGS    = 10;

    // system clock and nominal master clock rates
    localparam int SYS_CLK_HZ  = 20000000;
    localparam int MCLK_FAST_HZ = 4000000;
    localparam int MCLK_LOW_HZ  = 1800000;

    // master clock edges per sequence (plain defaults)
    localparam int CONV_TICKS  = 16;
    localparam int CAL_TICKS   = 64;

    // write address field of a complete word
    localparam int ADDR_HI_BIT = 15;
    localparam int ADDR_LO_BIT = 14;
    localparam logic [1:0] WR_NONE = 2'h0;
    localparam logic [1:0] WR_TEST = 2'h1;
    localparam logic [1:0] WR_CAL  = 2'h2;
    localparam logic [1:0] WR_CTRL = 2'h3;

    // read select codes
    localparam logic [1:0] RD_DATA   = 2'h0;
    localparam logic [1:0] RD_TEST   = 2'h1;
    localparam logic [1:0] RD_CAL    = 2'h2;
    localparam logic [1:0] RD_STATUS = 2'h3;

    // control register field positions
    localparam int CTL_CHAN_LO  = 10;
    localparam int CTL_PMGT_LO  = 8;
    localparam int CTL_RDSEL_LO = 6;
    localparam int CTL_AMODE    = 5;
    localparam int CTL_CONVST   = 4;

    // high byte select sits on the ninth data pin in byte mode
    localparam int HBSEL_BIT    = 8;

    // reset values
    localparam logic [REG_W-1:0]  CTRL_RST = 14'h0000;
    localparam logic [REG_W-1:0]  TEST_RST = 14'h0000;
    localparam logic [REG_W-1:0]  CAL_RST  = 14'h0000;
    localparam logic [CODE_W-1:0] CODE_RST = 12'h000;

    // status register field positions
    localparam int ST_BUSY      = 0;
    localparam int ST_CALIB     = 1;
    localparam int ST_PMGT_LO   = 2;
    localparam int ST_SLEEP     = 4;
    localparam int ST_PTR_LO    = 5;
    localparam int ST_RDSEL_LO  = 9;

    typedef enum logic [1:0] {ADCP_IDLE, ADCP_CONV, ADCP_CALIB} adcp_state_e;
endpackage : adcp_pkg

// ### design/adcp_port.sv
`timescale 1ns/10ps
// Contract
// - word mode high: transfers use all sixteen data pins as one word.
// - byte mode: only low eight pins carry data, ninth pin is high-byte select.
// - high-byte select low moves low byte, high moves high byte.
// - data pins are three-state, driven only under chip select and read.
// - results straight binary when unipolar, twos complement when bipolar.
// - master clock input times every conversion and calibration.
// - calibrate input held low resets all internal logic.
// - rising calibrate edge starts calibration, overriding other operations.
// - busy high from start until conversion or calibration finishes.
// - power-down mode comes from sleep input and two power bits.
// - power-up defaults let host write only channel setup before use.
// - write-only control, read-only data and status, read/write test and ten cal.
// - word mode: lowest pin is bit 0, sixteenth pin is bit 15.
// - byte mode: lowest pin is byte bit 0, eighth pin byte bit 7.
// - top two written bits select register, low fourteen are stored.
// - select code 00 updates no register.
// - 01 goes to test, 10 to current calibration, 11 to control.
// - two control bits pick the read source, 00 data at power-up.
module adcp_port
    import adcp_pkg::*;
#(
    parameter int CONV_LEN = CONV_TICKS,
    parameter int CAL_LEN  = CAL_TICKS
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              csN,
    input  wire logic              rdN,
    input  wire logic              wrN,
    input  wire logic              wordMode,
    input  wire logic [DATA_W-1:0] dataIn,
    output logic      [DATA_W-1:0] dataOut,
    output logic      [DATA_W-1:0] dataOe,
    input  wire logic              masterClk,
    input  wire logic              calPin,
    input  wire logic              sleepPin,
    input  wire logic              convStartPin,
    input  wire logic [CODE_W-1:0] sampleCode,
    output logic                   busy,
    output logic                   calibrating,
    output logic      [2:0]        powerMode,
    output logic      [REG_W-1:0]  ctrlWord
);

    // two-stage synchronisers for every pin input
    localparam int NSYNC = DATA_W + 8;
    // strobes and calibrate start at their idle high level
    localparam logic [NSYNC-1:0] SYNC_IDLE = 24'h0000e4;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;
    wire  [NSYNC-1:0] pinsRaw = {dataIn, csN, rdN, wrN, wordMode,
                                 masterClk, calPin, sleepPin, convStartPin};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            syncA <= SYNC_IDLE; // no false strobe or cal edge
            syncB <= SYNC_IDLE;
        end else begin
            syncA <= pinsRaw;
            syncB <= syncA;
        end
    end

    // named views of synchronised pins
    wire [DATA_W-1:0] dataS   = syncB[NSYNC-1 -: DATA_W];
    wire              csS     = syncB[7];
    wire              rdS     = syncB[6];
    wire              wrS     = syncB[5];
    wire              wordS   = syncB[4];
    wire              mclkS   = syncB[3];
    wire              calS    = syncB[2];
    wire              sleepS  = syncB[1];
    wire              convS   = syncB[0];

    // delayed copies for edge detection
    logic mclkD;
    logic calD;
    logic convD;
    logic wrActD;
    logic rdActD;

    wire calHeldLow = ~calS;
    wire wrAct      = ~csS & ~wrS;
    wire rdAct      = ~csS & ~rdS;
    wire mclkTick   = mclkS & ~mclkD;
    wire calRise    = calS & ~calD;
    wire convRise   = convS & ~convD;
    wire wrTake     = wrActD & ~wrAct;
    wire rdDone     = rdActD & ~rdAct;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mclkD  <= 1'b0;
            calD   <= 1'b1;
            convD  <= 1'b0;
            wrActD <= 1'b0;
            rdActD <= 1'b0;
        end else begin
            mclkD  <= mclkS;
            calD   <= calS;
            convD  <= convS;
            wrActD <= wrAct;
            rdActD <= rdAct;
        end
    end

    // data and mode seen during the write strobe
    logic [DATA_W-1:0] wrData;
    logic              wrWord;
    logic              rdHigh;

    // full-read flag taken while the read strobe is still low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            rdHigh <= 1'b0;
        else if (rdAct)
            rdHigh <= wordS | dataS[HBSEL_BIT];
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wrData <= '0;
            wrWord <= 1'b0;
        end else if (wrAct) begin
            wrData <= dataS;
            wrWord <= wordS;
        end
    end

    // byte assembly: low byte held until high byte arrives
    logic [BYTE_W-1:0] lowHeld;
    wire               wrHigh    = wrData[HBSEL_BIT];
    wire               byteLow   = wrTake & ~wrWord & ~wrHigh;
    wire               byteHigh  = wrTake & ~wrWord & wrHigh;
    wire               fullWrite = (wrTake & wrWord) | byteHigh;
    wire [DATA_W-1:0]  fullWord  = wrWord ? wrData
                                 : {wrData[BYTE_W-1:0], lowHeld};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lowHeld <= '0;
        end else if (calHeldLow) begin
            lowHeld <= '0;
        end else if (byteLow) begin
            lowHeld <= wrData[BYTE_W-1:0];
        end
    end

    // address decode of a complete word
    wire [1:0]       wrAddr  = fullWord[ADDR_HI_BIT:ADDR_LO_BIT];
    wire [REG_W-1:0] wrField = fullWord[REG_W-1:0];
    wire selTest = fullWrite & (wrAddr == WR_TEST);
    wire selCal  = fullWrite & (wrAddr == WR_CAL);
    wire selCtrl = fullWrite & (wrAddr == WR_CTRL);

    // control and test registers
    logic [REG_W-1:0] ctrl;
    logic [REG_W-1:0] testReg;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl    <= CTRL_RST;
            testReg <= TEST_RST;
        end else if (calHeldLow) begin
            ctrl    <= CTRL_RST;
            testReg <= TEST_RST;
        end else begin
            if (selCtrl)
                ctrl <= wrField;
            if (selTest)
                testReg <= wrField;
        end
    end

    // control fields
    wire [1:0] readSel  = ctrl[CTL_RDSEL_LO +: 2];
    wire [1:0] powerBits = ctrl[CTL_PMGT_LO +: 2];
    wire       bipolar  = ctrl[CTL_AMODE];
    wire       swConv   = selCtrl & wrField[CTL_CONVST];

    // calibration register file with a shared pointer
    logic [REG_W-1:0] calRegs [CAL_REGS];
    logic [3:0]       calPtr;
    wire  rdFull   = rdDone & rdHigh;
    wire  calRdAdv = rdFull & (readSel == RD_CAL);
    wire  ptrAdv   = selCal | calRdAdv;
    wire  ptrWrap  = (calPtr == 4'(CAL_REGS - 1));
    wire [3:0] next_calPtr = selCtrl ? 4'h0
                           : ptrWrap ? 4'h0 : calPtr + 4'h1;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            calPtr <= 4'h0;
        end else if (calHeldLow) begin
            calPtr <= 4'h0;
        end else if (selCtrl | ptrAdv) begin
            calPtr <= next_calPtr;
        end
    end

    // one generate entry per calibration register
    for (genvar i = 0; i < CAL_REGS; i++) begin : gCal
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst)
                calRegs[i] <= CAL_RST;
            else if (calHeldLow)
                calRegs[i] <= CAL_RST;
            else if (selCal && calPtr == 4'(i))
                calRegs[i] <= wrField;
        end
    end

    // conversion and calibration sequencer
    adcp_state_e      state;
    logic [7:0]       tickCnt;
    logic [CODE_W-1:0] resultCode;
    wire  startCal  = calRise;
    wire  startConv = (convRise | swConv) & (state == ADCP_IDLE);
    wire [7:0] convLast = 8'(CONV_LEN - 1);
    wire [7:0] calLast  = 8'(CAL_LEN - 1);
    wire  seqLast   = mclkTick & (state == ADCP_CONV ? tickCnt == convLast
                                                     : tickCnt == calLast);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state      <= ADCP_IDLE;
            tickCnt    <= 8'h00;
            resultCode <= CODE_RST;
        end else if (calHeldLow) begin
            state      <= ADCP_IDLE;
            tickCnt    <= 8'h00;
            resultCode <= CODE_RST;
        end else if (startCal) begin
            state   <= ADCP_CALIB;
            tickCnt <= 8'h00;
        end else begin
            case (state)
                ADCP_IDLE: begin
                    tickCnt <= 8'h00;
                    if (startConv)
                        state <= ADCP_CONV;
                end
                ADCP_CONV, ADCP_CALIB: begin
                    if (seqLast) begin
                        state   <= ADCP_IDLE;
                        tickCnt <= 8'h00;
                        if (state == ADCP_CONV)
                            resultCode <= sampleCode;
                    end else if (mclkTick) begin
                        tickCnt <= tickCnt + 8'h01;
                    end
                end
                default: state <= ADCP_IDLE;
            endcase
        end
    end

    // output coding and status word
    wire [CODE_W-1:0] codedResult = bipolar
        ? {~resultCode[CODE_W-1], resultCode[CODE_W-2:0]}
        : resultCode;
    wire [DATA_W-1:0] dataWord = {4'h0, codedResult};
    wire [DATA_W-1:0] statusWord = DATA_W'(
          ({15'h0000, busy}           << ST_BUSY)
        | ({15'h0000, calibrating}    << ST_CALIB)
        | ({14'h0000, powerBits}      << ST_PMGT_LO)
        | ({15'h0000, sleepS}         << ST_SLEEP)
        | ({12'h000, calPtr}          << ST_PTR_LO)
        | ({14'h0000, readSel}        << ST_RDSEL_LO));

    // read source selection
    wire [DATA_W-1:0] readWord =
          (readSel == RD_TEST)   ? {2'h0, testReg}
        : (readSel == RD_CAL)    ? {2'h0, calRegs[calPtr]}
        : (readSel == RD_STATUS) ? statusWord
        : dataWord;
    wire [DATA_W-1:0] byteView = dataS[HBSEL_BIT]
        ? {8'h00, readWord[DATA_W-1:BYTE_W]}
        : {8'h00, readWord[BYTE_W-1:0]};
    wire [DATA_W-1:0] next_dataOut = wordS ? readWord : byteView;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            dataOut <= '0;
        else
            dataOut <= next_dataOut;
    end

    // pins driven only during a read; byte mode leaves upper pins free
    wire [DATA_W-1:0] laneMask = wordS ? 16'hffff : 16'h00ff;
    assign dataOe = (rdAct & rdActD) ? laneMask : 16'h0000;

    // status outputs
    assign busy        = (state != ADCP_IDLE);
    assign calibrating = (state == ADCP_CALIB);
    assign powerMode   = {sleepS, powerBits};
    assign ctrlWord    = ctrl;

endmodule : adcp_port

// ### testbench/adcp_host.sv
`timescale 1ns/10ps
module adcp_host
    import adcp_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic [DATA_W-1:0] dataOut,
    input  wire logic [DATA_W-1:0] dataOe,
    output logic                   csN,
    output logic                   rdN,
    output logic                   wrN,
    output logic                   wordMode,
    output logic      [DATA_W-1:0] dataIn
);
    logic [DATA_W-1:0] drv;
    logic              hostOe;
    // device wins where enabled; a released host shows the inverse
    assign dataIn = (dataOe & dataOut) | (~dataOe & (hostOe ? drv : ~drv));
    initial begin
        {csN, rdN, wrN, wordMode, hostOe, drv} = {4'hf, 1'b0, 16'h0};
    end
    // one transfer: strobes low five cycles, data taken, then idle
    task automatic strobe(input logic wm, input logic wr,
                          input logic [DATA_W-1:0] v,
                          output logic [DATA_W-1:0] q);
        @(negedge sys_clk);
        wordMode = wm;
        drv = v;
        hostOe = 1'b1;
        csN = 1'b0;
        wrN = ~wr;
        rdN = wr;
        repeat (5) @(negedge sys_clk);
        q = dataOut;
        {csN, rdN, wrN, hostOe} = 4'he;
        repeat (6) @(negedge sys_clk);
    endtask : strobe
endmodule : adcp_host

// ### testbench/adcp_port_bench.sv
`timescale 1ns/10ps
module adcp_port_bench;
    import adcp_pkg::*;
    logic              sys_clk, nrst, masterClk, calPin, sleepPin;
    logic              convStartPin, busy, calibrating;
    logic              csN, rdN, wrN, wordMode;
    logic [DATA_W-1:0] dataIn, dataOut, dataOe, q, w;
    logic [CODE_W-1:0] sampleCode;
    logic [REG_W-1:0]  ctrlWord, v, t;
    logic [2:0]        powerMode;
    logic [31:0]       seed;
    int                miscompares, samples_checked;

    adcp_port #(.CONV_LEN(3), .CAL_LEN(4)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .csN(csN), .rdN(rdN), .wrN(wrN),
        .wordMode(wordMode), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .masterClk(masterClk), .calPin(calPin),
        .sleepPin(sleepPin), .convStartPin(convStartPin),
        .sampleCode(sampleCode), .busy(busy), .calibrating(calibrating),
        .powerMode(powerMode), .ctrlWord(ctrlWord));
    adcp_host host (
        .sys_clk(sys_clk), .dataOut(dataOut), .dataOe(dataOe), .csN(csN),
        .rdN(rdN), .wrN(wrN), .wordMode(wordMode), .dataIn(dataIn));

    // system clock, and a master clock toggling on falling edges
    always #25 sys_clk = ~sys_clk;
    always #100 masterClk = ~masterClk;

    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt

    // result word: four leading zeros, msb flipped when bipolar
    function automatic logic [DATA_W-1:0] exp_data(input logic [11:0] c,
                                                   input logic b);
        return {4'h0, c[11] ^ b, c[10:0]};
    endfunction : exp_data

    task automatic chk(input logic [DATA_W-1:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // bounded wait on busy (sel 0) or calibrating (sel 1)
    task automatic wait_lvl(input logic sel, input logic lvl);
        int n;
        n = 0;
        while ((sel ? calibrating : busy) !== lvl && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 400) begin
            chk({15'h0, sel ? calibrating : busy}, {15'h0, lvl});
            wrap_up();
        end
    endtask : wait_lvl

    task automatic convert(input logic bip);
        seed = nxt(seed);
        sampleCode = seed[CODE_W-1:0];
        convStartPin = 1'b1;
        wait_lvl(1'b0, 1'b1);
        convStartPin = 1'b0;
        wait_lvl(1'b0, 1'b0);
        host.strobe(1'b1, 1'b0, 16'h0, q);
        chk(q, exp_data(sampleCode, bip));
    endtask : convert

    initial begin
        {sys_clk, masterClk, nrst, calPin, sleepPin, convStartPin} = 6'h04;
        sampleCode = 12'h0;
        seed = 32'h00004fb7;
        miscompares = 0;
        samples_checked = 0;
        repeat (4) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({2'h0, ctrlWord}, 16'h0);
        convert(1'b0);
        for (int i = 0; i < 6; i++) begin
            seed = nxt(seed);
            v = seed[REG_W-1:0] & 14'h3fe0;
            sleepPin = seed[20];
            host.strobe(1'b1, 1'b1, {WR_CTRL, v}, q);
            chk({2'h0, ctrlWord}, {2'h0, v});
            chk({13'h0, powerMode}, {13'h0, seed[20], v[9:8]});
            host.strobe(1'b1, 1'b1, {WR_NONE, ~v}, q);
            chk({2'h0, ctrlWord}, {2'h0, v});
            w = {WR_CTRL, v ^ 14'h3c60};
            host.strobe(1'b0, 1'b1, {8'h00, w[7:0]}, q);
            chk({2'h0, ctrlWord}, {2'h0, v});
            host.strobe(1'b0, 1'b1, {8'h01, w[15:8]}, q);
            chk({2'h0, ctrlWord}, {2'h0, w[13:0]});
        end
        t = seed[REG_W+3:4];
        host.strobe(1'b1, 1'b1, {WR_TEST, t}, q);
        host.strobe(1'b1, 1'b1, {WR_CTRL, 14'h0040}, q);
        host.strobe(1'b1, 1'b0, 16'h0, q);
        chk({2'h0, q[REG_W-1:0]}, {2'h0, t});
        host.strobe(1'b0, 1'b0, 16'h0, q);
        chk(q, {8'h0, t[7:0]});
        host.strobe(1'b0, 1'b0, 16'h0100, q);
        chk({10'h0, q[5:0]}, {10'h0, t[13:8]});
        host.strobe(1'b1, 1'b1, {WR_CTRL, 14'h0080}, q);
        host.strobe(1'b1, 1'b1, {WR_CAL, ~t}, q);
        host.strobe(1'b1, 1'b1, {WR_CTRL, 14'h0080}, q);
        host.strobe(1'b0, 1'b0, 16'h0000, q);
        chk(q, {8'h0, ~t[7:0]});
        host.strobe(1'b0, 1'b0, 16'h0100, q);
        chk(q, {10'h0, ~t[13:8]});
        host.strobe(1'b1, 1'b1, {WR_CTRL, 14'h0020}, q);
        convert(1'b1);
        calPin = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk({2'h0, ctrlWord}, 16'h0);
        calPin = 1'b1;
        wait_lvl(1'b1, 1'b1);
        wait_lvl(1'b0, 1'b0);
        convStartPin = 1'b1;
        wait_lvl(1'b0, 1'b1);
        convStartPin = 1'b0;
        calPin = 1'b0;
        repeat (3) @(negedge sys_clk);
        calPin = 1'b1;
        wait_lvl(1'b1, 1'b1);
        wait_lvl(1'b0, 1'b0);
        wrap_up();
    end
endmodule : adcp_port_bench

// ### testbench/adcp_props.sv
`timescale 1ns/10ps
module adcp_props
    import adcp_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              nrst,
    input wire logic              csN,
    input wire logic              rdN,
    input wire logic              wrN,
    input wire logic              wordMode,
    input wire logic [DATA_W-1:0] dataOe,
    input wire logic              calPin,
    input wire logic              sleepPin,
    input wire logic              busy,
    input wire logic              calibrating,
    input wire logic [2:0]        powerMode,
    input wire logic [REG_W-1:0]  ctrlWord
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // pin drive, sequencer and register checks
    oe_idle_a: assert property (rdN [*5] |-> dataOe == 16'h0)
        else $error("pins driven without read");
    oe_word_a: assert property ((wordMode && !csN && !rdN) [*5] |-> dataOe == 16'hffff)
        else $error("word read not on all pins");
    oe_byte_a: assert property ((!wordMode && !csN && !rdN) [*5] |-> dataOe == 16'h00ff)
        else $error("byte read not on low pins");
    cal_busy_a: assert property (calibrating |-> busy)
        else $error("calibrating without busy");
    cal_start_a: assert property ($rose(calPin) |-> ##[2:6] (busy && calibrating))
        else $error("calibration did not start");
    cal_clear_a: assert property (!calPin [*5] |-> ctrlWord == 14'h0 && !busy)
        else $error("calibrate low did not clear");
    ctrl_hold_a: assert property ((wrN && calPin) [*6] |-> $stable(ctrlWord))
        else $error("control changed without write");
    sleep_mode_a: assert property (sleepPin [*4] |-> powerMode[2])
        else $error("sleep not in power mode");
    pmgt_mode_a: assert property ($stable(ctrlWord) [*2] |-> powerMode[1:0] == ctrlWord[9:8])
        else $error("power bits not in power mode");
endmodule : adcp_props

bind adcp_port adcp_props u_props (
    .sys_clk(sys_clk), .nrst(nrst), .csN(csN), .rdN(rdN), .wrN(wrN),
    .wordMode(wordMode), .dataOe(dataOe), .calPin(calPin),
    .sleepPin(sleepPin), .busy(busy), .calibrating(calibrating),
    .powerMode(powerMode), .ctrlWord(ctrlWord)
);
